// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
  // ==========================================
  // widths
  localparam int CTRL_W = 8;
  localparam int RES_W = 10;
  localparam int PIN_W = 4;
  // ==========================================
  // control word layout and reset
  localparam int CHANNEL_SELECT_BIT_HIGH = 5;
  localparam int CHANNEL_SELECT_BIT_LOW = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  // ==========================================
  // serial clock edge numbers inside one conversion
  localparam logic [4:0] EDGES_PER_CONV = 5'h10;
  localparam logic [4:0] CTRL_EDGES = 5'h08;
  localparam logic [4:0] HOLD_EDGE = 5'h04;
  localparam logic [4:0] FIRST_DATA_EDGE = 5'h05;
  localparam logic [4:0] LAST_DATA_EDGE = 5'h0E;
  localparam logic [4:0] FIRST_SAR_RISE = 5'h04;
  localparam logic [4:0] LAST_SAR_RISE = 5'h0D;
  localparam logic [4:0] EDGE_ONE = 5'h01;
  localparam logic [4:0] EDGE_NONE = 5'h00;
  // ==========================================
  // converter
  localparam logic [9:0] SAR_MIDSCALE = 10'h200;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  // pin order {compHigh, din, sclk, csN}; chip select idles high
  localparam logic [3:0] PIN_RESET = 4'h1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONVERT = 2'b10,
    ST_GAP = 2'b11
  } conv_state_e;
endpackage

// ---- hw/conv_if.sv ----
`timescale 1ns/1ps
interface conv_if;
  logic start;
  logic step;
  logic compHigh;
  logic resBit;
  logic [9:0] code;
  modport ctrl(output start, output step, output compHigh, input resBit, input code);
  modport sar(input start, input step, input compHigh, output resBit, output code);
endinterface

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [PIN_W-1:0] pinIn,
  output logic [PIN_W-1:0] pinOut
);
  // ==========================================
  // three stages; the filtered level only moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : gSync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          s1_r <= PIN_RESET[g];
          s2_r <= PIN_RESET[g];
          s3_r <= PIN_RESET[g];
        end else begin
          s1_r <= pinIn[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          q_r <= PIN_RESET[g];
        end else if (s2_r == s3_r) begin
          q_r <= s3_r;
        end
      end
      assign pinOut[g] = q_r;
    end
  endgenerate
endmodule

// ---- hw/sar_engine.sv ----
`timescale 1ns/1ps
module sar_engine
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  conv_if.sar conv
);
  logic [9:0] code_r;
  logic [3:0] idx_r;
  logic resBit_r;

  // ==========================================
  // successive approximation, one decision per step, msb first
  // no calibration state: the first start after reset is already exact
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      code_r <= CODE_RESET;
      idx_r <= SAR_TOP_BIT;
      resBit_r <= 1'b0;
    end else if (conv.start) begin
      code_r <= SAR_MIDSCALE; // RL5
      idx_r <= SAR_TOP_BIT;
    end else if (conv.step) begin
      code_r[idx_r] <= conv.compHigh; // RL8
      if (idx_r != 4'h0) begin
        code_r[idx_r - 4'h1] <= 1'b1;
        idx_r <= idx_r - 4'h1;
      end
      resBit_r <= conv.compHigh;
    end
  end

  assign conv.code = code_r;
  assign conv.resBit = resBit_r;

  AST_SAR_MIDSCALE: assert property (@(posedge mclk) disable iff (!resetn) // RL8
    conv.start |=> code_r == SAR_MIDSCALE) else $error("sar did not restart at midscale");
  AST_SAR_DECIDE: assert property (@(posedge mclk) disable iff (!resetn) // RL8
    conv.step && !conv.start |=> resBit_r == $past(conv.compHigh))
    else $error("sar decision lost");
endmodule

// ---- hw/adc_serial_channel_control.sv ----
`timescale 1ns/1ps
// Functional notes
// [RL1] simultaneous chip select and clock falls start tracking; either order accepted
// [RL2] first eight rising clock edges of a conversion shift data in into control
// [RL3] channel loaded during a conversion is used by the following conversion
// [RL4] first conversion after power-up always converts channel zero
// [RL5] first conversion after power-up is valid with no dummy conversion
// [RL6] control bits 7, 6, 2, 1 and 0 have no effect
// [RL7] bits 5 to 3 pick channel n in plain binary; zero is default
// [RL8] result is 10-bit straight binary, 1024 steps, zero input gives zero
// [RL9] powered up while chip select low, down while high, except gap
// [RL10] continuous mode powers down from 16th fall to next 1st fall
// [RL11] each conversion is 16 clocks; conversions repeat while chip select low
// [RL12] host may use burst mode at low rates to save power
// [RL13] chip select rising before eight bits keeps the old channel selection
// [RL14] data out: zeros edges 1-4, result msb first 5-14, zeros 15-16
// [RL15] host frames with chip select and gives multiples of 16 rising edges
// [RL16] data out released and clock gated off while chip select high
// [RL17] track for the first 3 clocks, hold and convert for 13
module adc_serial_channel_control
  import adc_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  input wire logic compHigh,
  output logic dout,
  output logic doutOe,
  output logic [2:0] chanSel,
  output logic trackEn,
  output logic powerUp,
  output logic [9:0] dacCode
);

  // ==========================================
  // pin conditioning
  logic [PIN_W-1:0] pinF;
  logic csNF;
  logic sclkF;
  logic dinF;
  logic compF;

  pin_sync uSync (
    .mclk(mclk),
    .resetn(resetn),
    .pinIn({compHigh, din, sclk, csN}),
    .pinOut(pinF)
  );

  assign csNF = pinF[0];
  assign sclkF = pinF[1];
  assign dinF = pinF[2];
  assign compF = pinF[3];

  // ==========================================
  // edge detection on the filtered levels
  logic csND_r;
  logic sclkD_r;
  logic csFall;
  logic frameEnd;
  logic sclkRise;
  logic fallEv;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      csND_r <= 1'b1;
      sclkD_r <= 1'b0;
    end else begin
      csND_r <= csNF;
      sclkD_r <= sclkF;
    end
  end

  assign csFall = csND_r & ~csNF;
  assign frameEnd = ~csND_r & csNF;
  // clock edges only count inside a frame, which gates the clock off otherwise
  assign sclkRise = ~sclkD_r & sclkF & ~csNF; // RL16
  // a chip select fall with the clock already low, or falling with it,
  // stands in for the first falling edge
  assign fallEv = (sclkD_r & ~sclkF & ~csNF) | (csFall & ~sclkF); // RL1

  // ==========================================
  // edge counters, numbering restarts every 16 edges
  logic [4:0] fallCnt_r;
  logic [4:0] riseCnt_r;
  logic [4:0] fallNum;
  logic [4:0] riseNum;

  assign fallNum = (fallCnt_r == EDGES_PER_CONV) ? EDGE_ONE : fallCnt_r + EDGE_ONE; // RL11
  assign riseNum = (riseCnt_r == EDGES_PER_CONV) ? EDGE_ONE : riseCnt_r + EDGE_ONE; // RL11

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fallCnt_r <= EDGE_NONE;
    end else if (frameEnd || (csFall && !fallEv)) begin
      fallCnt_r <= EDGE_NONE;
    end else if (fallEv) begin
      fallCnt_r <= fallNum;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      riseCnt_r <= EDGE_NONE;
    end else if (frameEnd || csFall) begin
      riseCnt_r <= EDGE_NONE;
    end else if (sclkRise) begin
      riseCnt_r <= riseNum;
    end
  end

  // ==========================================
  // conversion phase
  conv_state_e state_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
    end else if (frameEnd) begin
      state_r <= ST_IDLE; // RL9
    end else if (csFall) begin
      state_r <= ST_TRACK; // RL1
    end else if (fallEv) begin
      case (fallNum)
        EDGE_ONE: begin
          state_r <= ST_TRACK; // RL10
        end
        HOLD_EDGE: begin
          state_r <= ST_CONVERT; // RL17
        end
        EDGES_PER_CONV: begin
          state_r <= ST_GAP; // RL10
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  assign trackEn = (state_r == ST_TRACK); // RL17
  assign powerUp = (state_r == ST_TRACK) || (state_r == ST_CONVERT); // RL9

  // ==========================================
  // control register, shifted in on rising edges 1 to 8
  logic [CTRL_W-1:0] shift_r;
  logic [CTRL_W-1:0] chanSelCtrl_r;
  logic ctrlLoad;

  assign ctrlLoad = sclkRise && (riseNum == CTRL_EDGES);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= CTRL_RESET;
    end else if (sclkRise && (riseNum <= CTRL_EDGES)) begin
      shift_r <= {shift_r[CTRL_W-2:0], dinF}; // RL2
    end
  end

  // a frame cut before rising edge 8 never loads the word, so the old word stays
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chanSelCtrl_r <= CTRL_RESET;
    end else if (ctrlLoad) begin
      chanSelCtrl_r <= {shift_r[CTRL_W-2:0], dinF}; // RL13
    end
  end

  // ==========================================
  // channel in use; only taken at a conversion's start, hence one late
  logic [2:0] curChan_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      curChan_r <= CHAN_RESET; // RL4
    end else if (csFall || (fallEv && (fallNum == EDGE_ONE))) begin
      // only the three select bits matter
      curChan_r <= chanSelCtrl_r[CHANNEL_SELECT_BIT_HIGH:CHANNEL_SELECT_BIT_LOW]; // RL3 RL6 RL7
    end
  end

  assign chanSel = curChan_r;

  // ==========================================
  // converter engine
  conv_if conv ();
  logic dataWin;
  logic dataEv_r;

  assign dataWin = (fallNum >= FIRST_DATA_EDGE) && (fallNum <= LAST_DATA_EDGE);
  assign conv.start = fallEv && (fallNum == HOLD_EDGE); // RL17
  // each bit is decided on the falling edge that shifts it out, so the comparator
  // round trip through its synchroniser gets a whole serial clock, not half of one
  assign conv.step = fallEv && dataWin; // RL14
  assign conv.compHigh = compF;
  assign dacCode = conv.code;

  sar_engine uSar (
    .mclk(mclk),
    .resetn(resetn),
    .conv(conv)
  );

  // ==========================================
  // serial data out
  logic dout_r;
  logic doutOe_r;

  // the decision lands in the engine on the falling edge, so it is driven one clock later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dataEv_r <= 1'b0;
    end else begin
      dataEv_r <= conv.step;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dout_r <= 1'b0;
    end else if (frameEnd) begin
      dout_r <= 1'b0;
    end else if (dataEv_r) begin
      dout_r <= conv.resBit; // RL14
    end else if (fallEv && !dataWin) begin
      dout_r <= 1'b0; // RL14
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      doutOe_r <= 1'b0;
    end else begin
      doutOe_r <= ~csNF; // RL16
    end
  end

  assign dout = dout_r;
  assign doutOe = doutOe_r;

  // ==========================================
  // checks
  logic firstConv_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      firstConv_r <= 1'b1;
    end else if (frameEnd || (fallEv && (fallNum == EDGES_PER_CONV))) begin
      // a first frame cut short still used up the first conversion
      firstConv_r <= 1'b0;
    end
  end

  sequence seqConvEnd;
    fallEv && (fallNum == EDGES_PER_CONV);
  endsequence

  sequence seqWake;
    fallEv && (fallNum == EDGE_ONE) && (state_r == ST_GAP) && !frameEnd;
  endsequence

  sequence seqDataBit;
    conv.step ##1 !frameEnd;
  endsequence

  AST_TRACK_ON_CS_FALL: assert property (@(posedge mclk) disable iff (!resetn) // RL1
    csFall |=> trackEn && powerUp) else $error("no track after chip select fall");
  AST_CTRL_LOAD: assert property (@(posedge mclk) disable iff (!resetn) // RL2
    ctrlLoad |=> chanSelCtrl_r == $past({shift_r[CTRL_W-2:0], dinF}))
    else $error("control word not loaded on eighth rise");
  AST_CHAN_NEXT: assert property (@(posedge mclk) disable iff (!resetn) // RL3
    fallEv && (fallNum == EDGE_ONE) && !csFall |=> chanSel == $past(chanSelCtrl_r[5:3]))
    else $error("channel not taken from control word");
  AST_FIRST_CHAN: assert property (@(posedge mclk) disable iff (!resetn) // RL4
    firstConv_r && powerUp |-> chanSel == 3'h0) else $error("first conversion not channel 0");
  AST_POWER_GAP: assert property (@(posedge mclk) disable iff (!resetn) // RL10
    seqConvEnd and !frameEnd |=> !powerUp && !trackEn) else $error("no gap power down");
  AST_WAKE: assert property (@(posedge mclk) disable iff (!resetn) // RL11
    seqWake |=> (powerUp && trackEn) [*2]) else $error("no wake for next conversion");
  AST_CS_HIGH: assert property (@(posedge mclk) disable iff (!resetn) // RL16
    frameEnd |=> !powerUp ##1 !doutOe && !powerUp) else $error("not idle after frame");
  AST_HOLD_AT_4: assert property (@(posedge mclk) disable iff (!resetn) // RL17
    fallEv && (fallNum == HOLD_EDGE) && !frameEnd |=> powerUp && !trackEn)
    else $error("hold not entered on fourth fall");
  AST_LEAD_ZERO: assert property (@(posedge mclk) disable iff (!resetn) // RL14
    fallEv && ((fallNum < FIRST_DATA_EDGE) || (fallNum > LAST_DATA_EDGE)) |=> !dout)
    else $error("padding bit not zero");
  AST_DATA_BIT: assert property (@(posedge mclk) disable iff (!resetn) // RL14
    seqDataBit |=> dout == $past(conv.resBit)) else $error("result bit not shifted out");
  AST_STEP_IN_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // RL17
    conv.step |-> state_r == ST_CONVERT) else $error("decision outside hold phase");
  AST_CTRL_KEEP: assert property (@(posedge mclk) disable iff (!resetn) // RL13
    !ctrlLoad |=> $stable(chanSelCtrl_r)) else $error("control word changed off eighth rise");
  AST_CS_HIGH_OFF: assert property (@(posedge mclk) disable iff (!resetn) // RL9
    csNF |=> !doutOe && !powerUp) else $error("powered or driving with chip select high");
  AST_OE_ON: assert property (@(posedge mclk) disable iff (!resetn) // RL16
    !csNF |=> doutOe) else $error("output not driven with chip select low");
endmodule

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  input wire logic dout,
  input wire logic doutOe,
  input wire logic trackEn,
  input wire logic powerUp,
  output logic csN,
  output logic sclk,
  output logic din
);
  // ==========================================
  // captured per conversion, msb = falling edge 1
  logic [15:0] datBits[4];
  logic [15:0] trkBits[4];
  logic [15:0] pwrBits[4];
  logic doutWire;

  // no pull on the line: a released output reads as z, never as a stale bit
  assign doutWire = doutOe ? dout : 1'bz;

  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end

  // ==========================================
  // one frame; sclk idles high and stands still between frames
  task automatic frame(input logic [7:0] words[4], input int cycles, input bit lowStart);
    int c;
    int k;
    @(negedge mclk);
    csN = 1'b0;
    // with lowStart the first clock fall below lands in this same step as chip select
    if (!lowStart) begin
      repeat (4) @(negedge mclk);
    end
    for (int n = 0; n < cycles; n++) begin
      c = n / 16;
      k = n % 16;
      sclk = 1'b0;
      din = (k < 8) ? words[c][7 - k] : 1'($urandom);
      repeat (4) @(negedge mclk);
      sclk = 1'b1;
      repeat (3) @(negedge mclk);
      // sampled late in the cycle so the bit of this falling edge has landed
      datBits[c][15 - k] = doutWire;
      trkBits[c][15 - k] = trackEn;
      pwrBits[c][15 - k] = powerUp;
      @(negedge mclk);
    end
    csN = 1'b1;
    din = ~din;
    repeat (12) @(negedge mclk);
  endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import adc_ctrl_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn;
  logic compHigh;
  logic csN;
  logic sclk;
  logic din;
  logic dout;
  logic doutOe;
  logic [2:0] chanSel;
  logic trackEn;
  logic powerUp;
  logic [9:0] dacCode;
  logic [RES_W-1:0] lvl[8];
  logic [2:0] curCh;
  int fail_count = 0;
  int comparisons = 0;
  int n;

  always #12.5 mclk = ~mclk;

  // analog side: comparator against the level of the selected channel
  always @(negedge mclk) compHigh <= (lvl[chanSel] >= dacCode);

  adc_serial_channel_control dut (
    .mclk(mclk),
    .resetn(resetn),
    .csN(csN),
    .sclk(sclk),
    .din(din),
    .compHigh(compHigh),
    .dout(dout),
    .doutOe(doutOe),
    .chanSel(chanSel),
    .trackEn(trackEn),
    .powerUp(powerUp),
    .dacCode(dacCode)
  );

  host_model host (
    .mclk(mclk),
    .dout(dout),
    .doutOe(doutOe),
    .trackEn(trackEn),
    .powerUp(powerUp),
    .csN(csN),
    .sclk(sclk),
    .din(din)
  );

  // ==========================================
  // checking and reporting
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // expected result comes from the channel latched one conversion earlier
  function automatic logic [15:0] expWord(input logic [2:0] ch);
    return {4'h0, lvl[ch], 2'b00};
  endfunction

  task automatic run(input int nConv, input int cycles, input bit lowStart, input logic [2:0] ch);
    logic [7:0] w[4];
    for (int i = 0; i < 4; i++) w[i] = 8'($urandom);
    w[0][5:3] = ch;
    host.frame(w, cycles, lowStart);
    for (int c = 0; c < nConv; c++) begin
      if (c * 16 + 16 <= cycles) begin
        check(host.datBits[c], expWord(curCh));
        check(host.trkBits[c], 16'hE000);
        check(host.pwrBits[c], 16'hFFFE);
      end
      // a frame cut before the eighth rising edge leaves the channel alone
      if (c * 16 + 8 <= cycles) curCh = w[c][5:3];
    end
    check({13'h0000, doutOe, trackEn, powerUp}, 16'h0000);
    $display("frame done: %0d conversions, %0d clocks", nConv, cycles);
  endtask

  // ==========================================
  // main sequence
  initial begin
    resetn = 1'b0;
    void'($urandom(32'h73C3));
    for (int i = 0; i < 8; i++) lvl[i] = 10'($urandom);
    lvl[0] = 10'h000;
    lvl[7] = 10'h3FF;
    curCh = 3'h0;
    repeat (20) @(negedge mclk);
    check({dacCode, chanSel, doutOe, trackEn, powerUp}, 16'h0000);
    resetn = 1'b1;
    repeat (6) @(negedge mclk);
    run(3, 48, 1'b0, 3'h6);
    run(2, 32, 1'b1, 3'h2);
    run(1, 5, 1'b0, 3'h7);
    run(1, 16, 1'b0, 3'h1);
    for (int i = 0; i < 8; i++) begin
      run(2, 32, 1'(i), 3'(i));
    end
    for (int i = 0; i < 10; i++) begin
      n = 1 + int'($urandom % 3);
      run(n, ($urandom % 4 == 0) ? n * 16 - 10 : n * 16, 1'($urandom), 3'($urandom));
    end
    // second reset between frames: the channel must fall back to zero
    resetn = 1'b0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    curCh = 3'h0;
    repeat (6) @(negedge mclk);
    run(2, 32, 1'b0, 3'h5);
    results();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    results();
  end
endmodule
